//--- hdl/psrpu_dev.sv
// Memory end: power-up initialization and hardware reset sequencing
`timescale 1ns/1ps
`default_nettype none
module psrpu_dev (
    input  wire logic                  sys_clk,
    input  wire logic                  resetn,
    psrpu_link_if.dev                  link,
    input  wire logic                  supply_ok,
    input  wire logic                  sleep_req,
    input  wire logic                  deep_down_req,
    input  wire logic [7:0]            cfg_wdata,
    input  wire logic                  cfg_we,
    output logic                       ready,
    output logic                       array_valid,
    output logic                       refresh_on,
    output logic                       xfer_active,
    output logic                       cs_ignored,
    output psrpu_pkg::psrpu_pwr_t      pwr_state,
    output logic [7:0]                 cfg_q,
    output logic [12:0]                refresh_row
);
    import psrpu_pkg::*;

    // ==========================================================
    // Sequencer
    psrpu_dev_t       st_q, st_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic [CNT_W-1:0] rph_q;

    wire rst_low   = !link.reset_n;
    wire cs_low    = !link.cs_n;
    wire init_done = (cnt_q >= CNT_W'(INIT_CYC - 1));          // [RULE1]
    wire rec_done  = (cnt_q >= CNT_W'(RH_CYC - 1)) && (rph_q >= CNT_W'(RPH_CYC - 1));

    always_comb begin
        st_d  = st_q;
        cnt_d = cnt_q + CNT_W'(1);
        case (st_q)
            PSRPU_D_OFF: begin
                cnt_d = '0;
                if (supply_ok && !rst_low) begin
                    st_d = PSRPU_D_INIT;                      // [RULE3]
                end
            end
            PSRPU_D_INIT: begin
                if (init_done) begin
                    st_d = PSRPU_D_READY;                     // [RULE1]
                end
            end
            PSRPU_D_RESET: begin
                cnt_d = '0;
                if (!rst_low) begin
                    st_d = PSRPU_D_RECOVER;
                end
            end
            PSRPU_D_RECOVER: begin
                if (rec_done) begin
                    st_d = PSRPU_D_READY;
                end
            end
            default: begin
                cnt_d = '0;
            end
        endcase
        // Hardware path overrides state: supply loss from any state, reset low from any but OFF
        if (!supply_ok) begin
            st_d  = PSRPU_D_OFF;
            cnt_d = '0;
        end else if (rst_low && st_q != PSRPU_D_OFF) begin
            st_d  = PSRPU_D_RESET;                            // [RULE6]
            cnt_d = '0;
        end
    end

    // Counts from the reset falling edge, for the 400 ns spacing
    logic [CNT_W-1:0] rph_d;
    wire  rph_sat = (rph_q >= CNT_W'(RPH_CYC - 1));
    always_comb begin
        rph_d = rph_q;
        if (st_q != PSRPU_D_RESET && st_d == PSRPU_D_RESET) begin
            rph_d = '0;
        end else if (!rph_sat) begin
            rph_d = rph_q + CNT_W'(1);
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            st_q  <= PSRPU_D_OFF;
            cnt_q <= '0;
            rph_q <= '0;
        end else begin
            st_q  <= st_d;
            cnt_q <= cnt_d;
            rph_q <= rph_d;
        end
    end

    // ==========================================================
    // Select handling: refused until ready
    wire in_reset   = (st_d == PSRPU_D_RESET) || (st_d == PSRPU_D_OFF);
    wire sel_ok     = (st_q == PSRPU_D_READY) && cs_low;
    wire sel_bad    = (st_q != PSRPU_D_READY) && cs_low;        // [RULE16]
    wire in_wake    = (st_q == PSRPU_D_READY);

    // Power state: select wakes from sleep; reset forces active
    psrpu_pwr_t pwr_d;
    always_comb begin
        pwr_d = pwr_state;
        if (in_reset) begin
            pwr_d = PSRPU_PWR_ACTIVE;                         // [RULE9]
        end else if (in_wake && !cs_low && pwr_state == PSRPU_PWR_ACTIVE) begin
            if (deep_down_req) begin
                pwr_d = PSRPU_PWR_DEEP_DOWN;
            end else if (sleep_req) begin
                pwr_d = PSRPU_PWR_HYBRID_SLEEP;
            end
        end else if (sel_ok && pwr_state == PSRPU_PWR_HYBRID_SLEEP) begin
            pwr_d = PSRPU_PWR_ACTIVE;
        end
    end

    // Refresh runs whenever powered, out of reset and not in deep power-down
    wire refresh_d = !in_reset && (pwr_d != PSRPU_PWR_DEEP_DOWN);   // [RULE8]

    // ==========================================================
    // Named decodes feeding the output registers
    wire        ready_d  = (st_d == PSRPU_D_READY);
    wire        xfer_d   = sel_ok && (pwr_state != PSRPU_PWR_DEEP_DOWN);  // [RULE16]
    wire        init_fin = (st_q == PSRPU_D_INIT) && (st_d == PSRPU_D_READY);
    wire        cfg_load = cfg_we && sel_ok;
    // Row counter wraps on purpose: it only marks refresh progress
    wire [12:0] row_next = refresh_row + 13'h0001;

    // ==========================================================
    // Select outcome
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            ready       <= 1'b0;
            cs_ignored  <= 1'b0;
            xfer_active <= 1'b0;
        end else begin
            ready       <= ready_d;
            cs_ignored  <= sel_bad;                           // [RULE16]
            xfer_active <= xfer_d;                            // [RULE16]
        end
    end

    // ==========================================================
    // Power state and refresh enable
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            pwr_state  <= PSRPU_PWR_ACTIVE;
            refresh_on <= 1'b0;
        end else begin
            pwr_state  <= pwr_d;                              // [RULE9]
            refresh_on <= refresh_d;                          // [RULE8]
        end
    end

    // ==========================================================
    // Array validity
    // Lost in reset; only a full init makes it trusted again
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            array_valid <= 1'b0;
        end else if (in_reset) begin
            array_valid <= 1'b0;                              // [RULE8]
        end else if (init_fin) begin
            array_valid <= 1'b1;
        end
    end

    // ==========================================================
    // Configuration
    // Defaults win over a write in the same cycle: reset is hardware
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            cfg_q <= CFG_DEFAULT;
        end else if (in_reset) begin
            cfg_q <= CFG_DEFAULT;                             // [RULE7]
        end else if (cfg_load) begin
            cfg_q <= cfg_wdata;
        end
    end

    // ==========================================================
    // Self-refresh row counter
    // Restart loses refresh history, so some rows may age out
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            refresh_row <= REFRESH_ROW_INIT;
        end else if (in_reset) begin
            refresh_row <= REFRESH_ROW_INIT;                  // [RULE10]
        end else if (refresh_d) begin
            refresh_row <= row_next;
        end
    end

endmodule
`default_nettype wire

//--- hdl/psrpu_host.sv
// Controller end: drives reset and chip select with the required spacing
`timescale 1ns/1ps
`default_nettype none
module psrpu_host (
    input  wire logic  sys_clk,
    input  wire logic  resetn,
    psrpu_link_if.host link,
    input  wire logic  supply_ok,
    input  wire logic  supply_dip,
    input  wire logic  hw_reset_req,
    input  wire logic  access_req,
    input  wire logic  access_done,
    output logic       host_ready,
    output logic       data_lost
);
    import psrpu_pkg::*;

    psrpu_host_t      st_q, st_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic             rst_n_q, cs_n_q;

    wire init_done = (cnt_q >= CNT_W'(INIT_CYC - 1));
    // Reset held RP then high for RH: covers 400 ns from falling edge too
    wire rp_done   = (cnt_q >= CNT_W'(RP_CYC - 1));
    wire rh_done   = (cnt_q >= CNT_W'(RPH_CYC - RP_CYC > RH_CYC ? RPH_CYC - RP_CYC - 1 : RH_CYC - 1));

    always_comb begin
        st_d  = st_q;
        cnt_d = cnt_q + CNT_W'(1);
        case (st_q)
            PSRPU_H_POWER_WAIT: begin
                cnt_d = '0;
                if (supply_ok) begin
                    st_d = PSRPU_H_INIT_WAIT;
                end
            end
            PSRPU_H_INIT_WAIT: begin
                if (init_done) begin
                    st_d  = PSRPU_H_IDLE;                     // [RULE2] [RULE4]
                    cnt_d = '0;
                end
            end
            PSRPU_H_RESET_LOW: begin
                if (rp_done) begin
                    st_d  = PSRPU_H_RESET_HIGH;               // [RULE12]
                    cnt_d = '0;
                end
            end
            PSRPU_H_RESET_HIGH: begin
                if (rh_done) begin
                    st_d  = PSRPU_H_IDLE;                     // [RULE13] [RULE14] [RULE15]
                    cnt_d = '0;
                end
            end
            PSRPU_H_IDLE: begin
                cnt_d = '0;
                if (access_req) begin
                    st_d = PSRPU_H_SELECTED;
                end
            end
            default: begin
                cnt_d = '0;
                if (access_done) begin
                    st_d = PSRPU_H_IDLE;
                end
            end
        endcase
        if (!supply_ok) begin
            st_d  = PSRPU_H_POWER_WAIT;
            cnt_d = '0;
        end else if ((supply_dip || hw_reset_req) && st_q != PSRPU_H_RESET_LOW
                     && st_q != PSRPU_H_POWER_WAIT) begin
            st_d  = PSRPU_H_RESET_LOW;                        // [RULE5]
            cnt_d = '0;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            st_q       <= PSRPU_H_POWER_WAIT;
            cnt_q      <= '0;
            rst_n_q    <= 1'b0;
            cs_n_q     <= 1'b1;
            host_ready <= 1'b0;
            data_lost  <= 1'b1;
        end else begin
            st_q       <= st_d;
            cnt_q      <= cnt_d;
            rst_n_q    <= (st_d != PSRPU_H_RESET_LOW);
            cs_n_q     <= (st_d != PSRPU_H_SELECTED);
            host_ready <= (st_d == PSRPU_H_IDLE);
            // Cleared by the first access after reload
            if (st_d == PSRPU_H_RESET_LOW || st_d == PSRPU_H_POWER_WAIT) begin
                data_lost <= 1'b1;                            // [RULE11]
            end else if (st_d == PSRPU_H_SELECTED) begin
                data_lost <= 1'b0;
            end
        end
    end

    assign link.reset_n = rst_n_q;
    assign link.cs_n    = cs_n_q;

endmodule
`default_nettype wire

//--- hdl/psrpu_link_if.sv
// Link between host controller and memory: reset and chip select
`timescale 1ns/1ps
`default_nettype none
interface psrpu_link_if;
    logic reset_n;
    logic cs_n;
    modport host (output reset_n, output cs_n);
    modport dev  (input reset_n, input cs_n);
endinterface
`default_nettype wire

//--- hdl/psrpu_pkg.sv
// Constants and types shared by both ends of the power-up and reset link
// Contract
// RULE1: Device finishes self-initialization within 150 us
// RULE2: Host keeps select high through power-up
// RULE3: Reset low postpones self-initialization start
// RULE4: Host issues no transactions during initialization
// RULE5: Host resets device after shallow supply dip
// RULE6: Reset low returns device to standby
// RULE7: Reset restores configuration registers to defaults
// RULE8: Reset low halts refresh, array invalid
// RULE9: Reset exits hybrid sleep and deep power-down
// RULE10: Reset returns refresh row counter to default
// RULE11: Host treats array lost after reset
// RULE12: Host holds reset low at least 200 ns
// RULE13: No transactions during reset or recovery
// RULE14: Select waits 200 ns after reset rises
// RULE15: Select waits 400 ns after reset falls
// RULE16: Device ignores select during initialization or recovery
package psrpu_pkg;

    localparam int unsigned CLK_PERIOD_NS = 4;

    // ==========================================================
    // Timing figures in their own units
    localparam int unsigned POWER_UP_INIT_TIME_US       = 150;
    localparam int unsigned SUPPLY_OFF_DURATION_US      = 50;
    localparam int unsigned RESET_PULSE_WIDTH_NS        = 200;
    localparam int unsigned RESET_HIGH_TO_SELECT_TIME_NS = 200;
    localparam int unsigned RESET_LOW_TO_SELECT_TIME_NS = 400;

    // ==========================================================
    // Cycle counts: maxima round down, minima round up
    localparam int unsigned INIT_CYC = (POWER_UP_INIT_TIME_US * 1000) / CLK_PERIOD_NS;
    localparam int unsigned RP_CYC   = (RESET_PULSE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned RH_CYC   = (RESET_HIGH_TO_SELECT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned RPH_CYC  = (RESET_LOW_TO_SELECT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam int unsigned CNT_W = 16;

    // ==========================================================
    // Reset values of device state
    localparam logic [7:0]  CFG_DEFAULT      = 8'h8f;
    localparam logic [12:0] REFRESH_ROW_INIT = 13'h0000;

    typedef enum logic [1:0] {
        PSRPU_PWR_ACTIVE,
        PSRPU_PWR_HYBRID_SLEEP,
        PSRPU_PWR_DEEP_DOWN
    } psrpu_pwr_t;

    typedef enum logic [2:0] {
        PSRPU_D_OFF,
        PSRPU_D_INIT,
        PSRPU_D_RESET,
        PSRPU_D_RECOVER,
        PSRPU_D_READY
    } psrpu_dev_t;

    typedef enum logic [2:0] {
        PSRPU_H_POWER_WAIT,
        PSRPU_H_INIT_WAIT,
        PSRPU_H_RESET_LOW,
        PSRPU_H_RESET_HIGH,
        PSRPU_H_IDLE,
        PSRPU_H_SELECTED
    } psrpu_host_t;

endpackage

//--- test/psram_power_up_and_hw_reset_tb_top.sv
// Bench joining host and memory ends across the link
`timescale 1ns/1ps
`default_nettype none
module psram_power_up_and_hw_reset_tb_top;
    import psrpu_pkg::*;
    logic        sys_clk = 1'b0, resetn = 1'b0, supply_ok = 1'b0, supply_dip = 1'b0, hw_reset_req = 1'b0;
    logic        access_req = 1'b0, access_done = 1'b0, sleep_req = 1'b0, deep_down_req = 1'b0, cfg_we = 1'b0;
    logic [7:0]  cfg_wdata = 8'h00, cfg_q;
    logic        ready, array_valid, refresh_on, xfer_active, cs_ignored, host_ready, data_lost;
    logic [12:0] refresh_row;
    psrpu_pwr_t  pwr_state;
    int          failures = 0, compares = 0;

    psrpu_link_if i_link();
    always #2 sys_clk = ~sys_clk;

    psrpu_host i_psrpu_host (.sys_clk(sys_clk), .resetn(resetn), .link(i_link.host), .supply_ok(supply_ok),
        .supply_dip(supply_dip), .hw_reset_req(hw_reset_req), .access_req(access_req),
        .access_done(access_done), .host_ready(host_ready), .data_lost(data_lost));
    psrpu_dev i_psrpu_dev (.sys_clk(sys_clk), .resetn(resetn), .link(i_link.dev), .supply_ok(supply_ok),
        .sleep_req(sleep_req), .deep_down_req(deep_down_req), .cfg_wdata(cfg_wdata), .cfg_we(cfg_we),
        .ready(ready), .array_valid(array_valid), .refresh_on(refresh_on), .xfer_active(xfer_active),
        .cs_ignored(cs_ignored), .pwr_state(pwr_state), .cfg_q(cfg_q), .refresh_row(refresh_row));
    psrpu_link_monitor i_mon (.sys_clk(sys_clk), .resetn(resetn), .reset_n(i_link.reset_n),
        .cs_n(i_link.cs_n), .ready(ready), .refresh_on(refresh_on), .xfer_active(xfer_active),
        .cs_ignored(cs_ignored));

    // ==========================================
    // Helpers
    task automatic end_sim;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(string n, logic [15:0] e, logic [15:0] g);
        compares++;
        if (g !== e) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic cyc(int n);
        repeat (n) @(negedge sys_clk);
    endtask

    // ==========================================
    // Scenarios
    task automatic t_power_up;
        int  n;
        logic sel;
        n = 0;
        sel = 1'b0;
        // Request held early: must be refused until both ends are ready
        access_req = 1'b1;
        supply_ok = 1'b1;
        while (!(ready === 1'b1 && host_ready === 1'b1)) begin
            sel |= (i_link.cs_n !== 1'b1);
            cyc(1);
            n++;
            if (n > INIT_CYC + 20) begin
                chk("init_timeout", 16'h0, 16'h1);
                end_sim();
            end
        end
        chk("init_in_time", 16'h1, 16'(n <= INIT_CYC + 3));
        chk("cs_early", 16'h0, 16'(sel));
        chk("lost_up", 16'h1, 16'(data_lost));
        chk("arr_up", 16'h1, 16'(array_valid));
        $display("test power_up done");
    endtask

    task automatic t_access;
        cyc(2);
        chk("cs_low", 16'h0, 16'(i_link.cs_n));
        chk("xfer", 16'h1, 16'(xfer_active));
        chk("cs_ign", 16'h0, 16'(cs_ignored));
        chk("lost_sel", 16'h0, 16'(data_lost));
        cfg_wdata = 8'h3c;
        cfg_we = 1'b1;
        cyc(1);
        cfg_we = 1'b0;
        access_req = 1'b0;
        access_done = 1'b1;
        cyc(2);
        access_done = 1'b0;
        chk("cfg_wr", 16'h3c, 16'(cfg_q));
        $display("test access done");
    endtask

    task automatic t_reset(int m);
        int lo;
        int hi;
        lo = 0;
        hi = 0;
        sleep_req = (m == 0);
        deep_down_req = (m == 1);
        cyc(3);
        chk("pwr_low", m == 0 ? 16'(PSRPU_PWR_HYBRID_SLEEP) : 16'(PSRPU_PWR_DEEP_DOWN), 16'(pwr_state));
        sleep_req = 1'b0;
        deep_down_req = 1'b0;
        hw_reset_req = (m == 0);
        supply_dip = (m == 1);
        cyc(1);
        hw_reset_req = 1'b0;
        supply_dip = 1'b0;
        while (i_link.reset_n !== 1'b0 && lo < 8) begin
            cyc(1);
            lo++;
        end
        if (lo >= 8) begin
            chk("rst_fall_timeout", 16'h0, 16'h1);
            end_sim();
        end
        lo = 0;
        cyc(2);
        chk("rdy_rst", 16'h0, 16'(ready));
        chk("pwr_rst", 16'(PSRPU_PWR_ACTIVE), 16'(pwr_state));
        chk("cfg_rst", 16'(CFG_DEFAULT), 16'(cfg_q));
        chk("row_rst", 16'(REFRESH_ROW_INIT), 16'(refresh_row));
        chk("ref_rst", 16'h0, 16'({refresh_on, array_valid}));
        chk("lost_rst", 16'h1, 16'(data_lost));
        while (i_link.reset_n === 1'b0 && lo < 400) begin
            cyc(1);
            lo++;
        end
        while (!(ready === 1'b1 && host_ready === 1'b1) && hi < 400) begin
            cyc(1);
            hi++;
        end
        if (lo >= 400 || hi >= 400) begin
            chk("recover_timeout", 16'h0, 16'h1);
            end_sim();
        end
        chk("rst_width", 16'h1, 16'(lo + 2 >= RP_CYC));
        chk("rst_recover", 16'h1, 16'(hi < 400 && lo + hi + 2 >= RPH_CYC));
        chk("ref_back", 16'h1, 16'(refresh_on));
        chk("row_run", 16'h1, 16'(refresh_row != REFRESH_ROW_INIT));
        access_req = 1'b1;
        $display("test reset %0d done", m);
    endtask

    initial begin
        cyc(4);
        resetn = 1'b1;
        cyc(1);
        t_power_up();
        for (int m = 0; m < 2; m++) begin
            t_access();
            t_reset(m);
        end
        t_access();
        end_sim();
    end
endmodule
`default_nettype wire

//--- test/psrpu_link_monitor.sv
// Checker of the reset and select link between the two ends
`timescale 1ns/1ps
`default_nettype none
module psrpu_link_monitor
    import psrpu_pkg::*;
(
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic reset_n,
    input wire logic cs_n,
    input wire logic ready,
    input wire logic refresh_on,
    input wire logic xfer_active,
    input wire logic cs_ignored
);
    logic [15:0] lo_q;
    logic [15:0] hi_q;
    logic [15:0] fall_q;
    logic        seen_q;

    // ==========================================
    // Run lengths, saturating so long waits never wrap
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            lo_q   <= 16'h0000;
            hi_q   <= 16'h0000;
            fall_q <= 16'h0000;
            seen_q <= 1'b0;
        end else begin
            lo_q   <= reset_n ? 16'h0000 : ((&lo_q) ? lo_q : lo_q + 16'h0001);
            hi_q   <= !reset_n ? 16'h0000 : ((&hi_q) ? hi_q : hi_q + 16'h0001);
            fall_q <= (!reset_n && lo_q == 16'h0000) ? 16'h0001 : ((&fall_q) ? fall_q : fall_q + 16'h0001);
            seen_q <= seen_q | ready;
        end
    end

    // ==========================================
    // Properties
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    sequence s_sel;
        $fell(cs_n);
    endsequence
    sequence s_rise;
        $rose(reset_n);
    endsequence

    // Power-up rise is not a reset pulse, hence seen_q
    property p_pulse; seen_q ##0 s_rise |-> lo_q >= RP_CYC; endproperty
    property p_rh; s_sel |-> hi_q >= RH_CYC; endproperty
    property p_rph; s_sel |-> fall_q >= RPH_CYC; endproperty
    property p_cs_rst; !reset_n |-> cs_n; endproperty
    property p_pwr; !seen_q |-> cs_n; endproperty
    property p_init; $rose(ready) |-> reset_n && hi_q > 0 && hi_q <= INIT_CYC + 2; endproperty
    property p_rst; $fell(reset_n) |=> !ready; endproperty
    property p_refresh; !reset_n |=> !refresh_on; endproperty
    property p_xfer; !ready |=> !xfer_active; endproperty
    property p_ign; s_sel ##0 !ready |=> cs_ignored; endproperty

    a_pulse: assert property (p_pulse) else $error("reset pulse too short");
    a_rh: assert property (p_rh) else $error("select too soon after reset rise");
    a_rph: assert property (p_rph) else $error("select too soon after reset fall");
    a_cs_rst: assert property (p_cs_rst) else $error("select while reset low");
    a_pwr: assert property (p_pwr) else $error("select during power-up");
    a_init: assert property (p_init) else $error("ready timing wrong");
    a_rst: assert property (p_rst) else $error("ready kept through reset");
    a_refresh: assert property (p_refresh) else $error("refresh during reset");
    a_xfer: assert property (p_xfer) else $error("transfer while not ready");
    a_ign: assert property (p_ign) else $error("early select not ignored");
endmodule
`default_nettype wire
